// file: core/wdt_top.sv
// watchdog timer behind an index/data port pair
//
// Contract
// - timeout of 1 to 255 units
// - reset output on expiry
// - index port selects, data port accesses register
// - activation bit enables, off after reset
// - unit bit: seconds clear, minutes set
// - fast bit ticks 1000 times faster
// - zero stops; nonzero sets count length
// - countdown write restarts the count
// - keyboard restart enable, clear after reset
// - force bit times out, self clears
// - status bit reads one after expiry
// - mouse restart enable restarts count
`timescale 1ns/1ps
`include "wdt_defs.svh"
module wdt_top #(
   parameter int unsigned CYC_PER_MS = `WDT_CYC_PER_MS
) (
   input  wire logic           i_sys_clk,
   input  wire logic           i_reset,
   input  wire wdt_pkg::wdt_io_s i_io,
   output logic [7:0]          o_rdata,
   input  wire logic           i_kbd_activity,
   input  wire logic           i_mouse_activity,
   output logic                o_wdt_reset
);
   import wdt_pkg::*;
   // ***************************
   // pin synchronisers
   // ***************************
   logic [1:0] kbd_sync_reg;
   logic [1:0] ms_sync_reg;
   logic       kbd_q_reg;
   logic       ms_q_reg;
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         kbd_sync_reg <= 2'h0;
         ms_sync_reg  <= 2'h0;
         kbd_q_reg    <= 1'b0;
         ms_q_reg     <= 1'b0;
      end else begin
         kbd_sync_reg <= {kbd_sync_reg[0], i_kbd_activity};
         ms_sync_reg  <= {ms_sync_reg[0], i_mouse_activity};
         kbd_q_reg    <= kbd_sync_reg[1];
         ms_q_reg     <= ms_sync_reg[1];
      end
   end
   wire kbd_edge = kbd_sync_reg[1] & ~kbd_q_reg;
   wire ms_edge  = ms_sync_reg[1] & ~ms_q_reg;
   // ***************************
   // lock sequence and index
   // ***************************
   wdt_lock_e  lock_reg;
   logic [7:0] index_reg;
   wire idx_wr = i_io.wr & (i_io.addr == `WDT_PORT_INDEX);
   wire dat_wr = i_io.wr & (i_io.addr == `WDT_PORT_DATA);
   wire open_w = (lock_reg == WDT_OPEN);
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         lock_reg <= WDT_LOCKED;
      end else if (idx_wr) begin
         case (lock_reg)
            WDT_LOCKED: lock_reg <= (i_io.wdata == `WDT_UNLOCK_CODE) ?
                                    WDT_HALF : WDT_LOCKED;
            WDT_HALF:   lock_reg <= (i_io.wdata == `WDT_UNLOCK_CODE) ?
                                    WDT_OPEN : WDT_LOCKED;
            WDT_OPEN:   lock_reg <= (i_io.wdata == `WDT_LOCK_CODE) ?
                                    WDT_LOCKED : WDT_OPEN;
            default:    lock_reg <= WDT_LOCKED;
         endcase
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         index_reg <= 8'h00;
      end else if (idx_wr && open_w &&
                   i_io.wdata != `WDT_LOCK_CODE) begin
         index_reg <= i_io.wdata;
      end
   end
   // ***************************
   // registers
   // ***************************
   logic [7:0] group_reg;
   logic       active_reg;
   logic       unit_min_reg;
   logic       fast_reg;
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic       kbd_en_reg;
   logic       ms_en_reg;
   logic       status_reg;
   logic       force_reg;
   wire grp_ok = (group_reg == `WDT_GROUP_WATCHDOG);
   wire acc_ok = open_w & dat_wr;
   wire wr_grp = acc_ok & (index_reg == `WDT_REG_GROUP_SEL);
   wire wr_act = acc_ok & grp_ok & (index_reg == `WDT_REG_ACTIVATE);
   wire wr_unt = acc_ok & grp_ok & (index_reg == `WDT_REG_UNIT_CTRL);
   wire wr_cnt = acc_ok & grp_ok & (index_reg == `WDT_REG_COUNTDOWN);
   wire wr_evt = acc_ok & grp_ok & (index_reg == `WDT_REG_EVENT_CTRL);
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         group_reg    <= 8'h00;
         active_reg   <= 1'b0;
         unit_min_reg <= 1'b0;
         fast_reg     <= 1'b0;
         kbd_en_reg   <= 1'b0;
         ms_en_reg    <= 1'b0;
      end else begin
         if (wr_grp) group_reg <= i_io.wdata;
         if (wr_act) active_reg <= i_io.wdata[`WDT_ACTIVATE_BIT];
         if (wr_unt) begin
            unit_min_reg <= i_io.wdata[`WDT_UNIT_MIN_BIT];
            fast_reg     <= i_io.wdata[`WDT_UNIT_FAST_BIT];
         end
         if (wr_evt) begin
            kbd_en_reg <= i_io.wdata[`WDT_EV_KBD_BIT];
            ms_en_reg  <= i_io.wdata[`WDT_EV_MOUSE_BIT];
         end
      end
   end
   // ***************************
   // read path
   // ***************************
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else if (i_io.rd && open_w && i_io.addr == `WDT_PORT_DATA) begin
         case (index_reg)
            `WDT_REG_GROUP_SEL:  o_rdata <= group_reg;
            `WDT_REG_ACTIVATE:   o_rdata <= {7'h00, active_reg};
            `WDT_REG_UNIT_CTRL:  o_rdata <= {3'h0, fast_reg,
                                             unit_min_reg, 3'h0};
            `WDT_REG_COUNTDOWN:  o_rdata <= count_reg;
            `WDT_REG_EVENT_CTRL: o_rdata <= {ms_en_reg, kbd_en_reg,
                                             force_reg, status_reg,
                                             4'h0};
            default:             o_rdata <= 8'h00;
         endcase
      end else if (i_io.rd) begin
         o_rdata <= (i_io.addr == `WDT_PORT_INDEX) ? index_reg : 8'h00;
      end
   end
   // ***************************
   // prescaler
   // ***************************
   logic [31:0] ms_cnt_reg;
   logic [9:0]  sub_cnt_reg;
   logic [5:0]  min_cnt_reg;
   logic [7:0]  load_reg;
   wire run     = active_reg & (count_reg != 8'h00);
   wire restart = wr_cnt | (kbd_en_reg & kbd_edge) |
                  (ms_en_reg & ms_edge);
   wire ms_tick = run & (ms_cnt_reg == CYC_PER_MS - 1);
   wire sec_tick = ms_tick & (sub_cnt_reg == 10'(`WDT_MS_PER_UNIT_S - 1));
   wire min_tick = sec_tick &
                   (min_cnt_reg == 6'(`WDT_UNITS_PER_MIN - 1));
   wire fmin_tick = ms_tick & (min_cnt_reg == 6'(`WDT_UNITS_PER_MIN - 1));
   logic unit_tick;
   always_comb begin
      case ({fast_reg, unit_min_reg})
         2'h0:    unit_tick = sec_tick;
         2'h1:    unit_tick = min_tick;
         2'h2:    unit_tick = ms_tick;
         default: unit_tick = fmin_tick;
      endcase
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_reset || restart || !run) begin
         ms_cnt_reg  <= 32'h0;
         sub_cnt_reg <= 10'h0;
         min_cnt_reg <= 6'h0;
      end else if (ms_tick) begin
         ms_cnt_reg  <= 32'h0;
         sub_cnt_reg <= sec_tick ? 10'h0 : sub_cnt_reg + 10'h1;
         if (fast_reg ? 1'b1 : sec_tick)
            min_cnt_reg <= (min_cnt_reg ==
                            6'(`WDT_UNITS_PER_MIN - 1)) ? 6'h0 :
                           min_cnt_reg + 6'h1;
      end else begin
         ms_cnt_reg <= ms_cnt_reg + 32'h1;
      end
   end
   // ***************************
   // countdown and timeout
   // ***************************
   // a restart in the expiry cycle wins over the timeout
   wire expire = run & unit_tick & (count_reg == 8'h01) &
                 ~restart;
   always_comb begin
      count_next = count_reg;
      if (wr_cnt) count_next = i_io.wdata;
      else if (restart) count_next = load_reg;
      else if (run && unit_tick) count_next = count_reg - 8'h01;
   end
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         count_reg <= 8'h00;
         load_reg  <= 8'h00;
      end else begin
         count_reg <= count_next;
         if (wr_cnt) load_reg <= i_io.wdata;
      end
   end
   wire force_set = wr_evt & i_io.wdata[`WDT_EV_FORCE_BIT];
   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         force_reg   <= 1'b0;
         status_reg  <= 1'b0;
         o_wdt_reset <= 1'b0;
      end else begin
         force_reg   <= force_set;
         o_wdt_reset <= expire | force_set;
         if (expire || force_set) status_reg <= 1'b1;
         else if (wr_evt && i_io.wdata[`WDT_EV_STATUS_BIT])
            status_reg <= 1'b0;
      end
   end
   // ***************************
   // checks
   // ***************************
   chk_reset_on_expire: assert property (@(posedge i_sys_clk)
      disable iff (i_reset) expire |=> o_wdt_reset)
      else $error("no reset pulse on expiry");
   chk_status_sticky: assert property (@(posedge i_sys_clk)
      disable iff (i_reset) (expire || force_set) |=> status_reg)
      else $error("status not set after timeout");
   chk_force_clears: assert property (@(posedge i_sys_clk)
      disable iff (i_reset) force_reg && !force_set |=> !force_reg)
      else $error("force bit did not self clear");
   chk_locked_ignore: assert property (@(posedge i_sys_clk)
      disable iff (i_reset) (lock_reg != WDT_OPEN) |=>
      $stable(index_reg) && $stable(load_reg) && $stable(group_reg) &&
      ($stable(count_reg) || $past(run) || $past(restart)))
      else $error("locked port altered registers");
   chk_count_load: assert property (@(posedge i_sys_clk)
      disable iff (i_reset) wr_cnt |=> count_reg == $past(i_io.wdata))
      else $error("countdown write not loaded");
   chk_restart_quiet: assert property (@(posedge i_sys_clk)
      disable iff (i_reset) (restart && !force_set) |=> !o_wdt_reset)
      else $error("timeout despite restart");
   chk_zero_stops: assert property (@(posedge i_sys_clk)
      disable iff (i_reset) (count_reg == 8'h00 && !wr_cnt && !restart)
      |=> count_reg == 8'h00)
      else $error("counter moved while stopped");
   chk_dec_one: assert property (@(posedge i_sys_clk)
      disable iff (i_reset) (run && unit_tick && !restart) |=>
      count_reg == $past(count_reg) - 8'h01)
      else $error("bad decrement");
   chk_unlock_twice: assert property (@(posedge i_sys_clk)
      disable iff (i_reset) (lock_reg == WDT_LOCKED && idx_wr) |=>
      lock_reg != WDT_OPEN)
      else $error("opened on one code");
   cov_expire: cover property (@(posedge i_sys_clk) expire);
   cov_force: cover property (@(posedge i_sys_clk) force_set);
   cov_kbd: cover property (@(posedge i_sys_clk) kbd_en_reg && kbd_edge);
endmodule // wdt_top

// file: shared/wdt_defs.svh
// constants for the index/data port watchdog
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH
`define WDT_PORT_INDEX      1'b0
`define WDT_PORT_DATA       1'b1
`define WDT_UNLOCK_CODE     8'h87
`define WDT_LOCK_CODE       8'haa
`define WDT_REG_GROUP_SEL   8'h07
`define WDT_REG_ACTIVATE    8'h30
`define WDT_REG_UNIT_CTRL   8'hf5
`define WDT_REG_COUNTDOWN   8'hf6
`define WDT_REG_EVENT_CTRL  8'hf7
`define WDT_GROUP_WATCHDOG  8'h08
`define WDT_ACTIVATE_BIT    0
`define WDT_UNIT_MIN_BIT    3
`define WDT_UNIT_FAST_BIT   4
`define WDT_EV_STATUS_BIT   4
`define WDT_EV_FORCE_BIT    5
`define WDT_EV_KBD_BIT      6
`define WDT_EV_MOUSE_BIT    7
`define WDT_CLK_HZ          25000000
`define WDT_MS_PER_S        1000
`define WDT_CYC_PER_MS      (`WDT_CLK_HZ / `WDT_MS_PER_S)
`define WDT_MS_PER_UNIT_S   1000
`define WDT_UNITS_PER_MIN   60
`endif

// file: shared/wdt_pkg.sv
// types for the index/data port watchdog
package wdt_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       addr;
      logic [7:0] wdata;
   } wdt_io_s;
   typedef enum logic [1:0] {
      WDT_LOCKED,
      WDT_HALF,
      WDT_OPEN
   } wdt_lock_e;
endpackage

// file: sim/wdt_top_tb.sv
// self-checking bench for the index/data port watchdog
`timescale 1ns/1ps
module wdt_top_tb;
   import wdt_pkg::*;
   // ****************************************
   // signals and design instance
   // ****************************************
   localparam int CPM = 2;
   localparam int TS  = CPM * 1000;
   logic       clk;
   logic       rst;
   wdt_io_s    io;
   logic [7:0] rdata;
   logic       kbd;
   logic       mouse;
   logic       wdt_rst;
   int         num_errors = 0;
   int         n_checks = 0;
   int         cyc = 0;
   int         pulses = 0;
   wdt_top #(.CYC_PER_MS(CPM)) dut_u (
      .i_sys_clk(clk), .i_reset(rst), .i_io(io), .o_rdata(rdata),
      .i_kbd_activity(kbd), .i_mouse_activity(mouse),
      .o_wdt_reset(wdt_rst));
   // ****************************************
   // clock, cycle and pulse counters
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wdt_rst === 1'b1) pulses <= pulses + 1;
   end
   // ****************************************
   // access tasks and comparisons
   // ****************************************
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(logic a, logic [7:0] d);
      @(posedge clk) io <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk) io <= '0;
   endtask
   task automatic set(logic [7:0] idx, logic [7:0] val);
      wr(1'b0, idx);
      wr(1'b1, val);
   endtask
   task automatic rd_chk(logic [7:0] idx, logic [7:0] exp, string what);
      wr(1'b0, idx);
      @(posedge clk) io <= '{wr: 1'b0, rd: 1'b1, addr: 1'b1, wdata: 8'h00};
      @(posedge clk) io <= '0;
      #1 check(what, rdata, exp);
   endtask
   task automatic pulse(int lo, int hi);
      int t0;
      int p0;
      t0 = cyc;
      p0 = pulses;
      while (pulses == p0 && cyc - t0 <= hi) @(posedge clk);
      check("expiry in window", 8'(pulses != p0 && cyc - t0 >= lo), 8'h01);
   endtask
   task automatic quiet(int n);
      int p0;
      p0 = pulses;
      repeat (n) @(posedge clk);
      check("no expiry", 8'(pulses - p0), 8'h00);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      summarize();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int p0;
      rst = 1'b1;
      io = '0;
      kbd = 1'b0;
      mouse = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      wr(1'b0, 8'h87);
      set(8'h07, 8'h08);
      rd_chk(8'hf7, 8'h00, "locked read");
      wr(1'b0, 8'h87);
      wr(1'b0, 8'h87);
      set(8'h07, 8'h08);
      rd_chk(8'h07, 8'h08, "group select");
      rd_chk(8'hf5, 8'h00, "unit reset");
      rd_chk(8'hf7, 8'h00, "event reset");
      set(8'hf5, 8'h10);
      set(8'hf6, 8'h02);
      quiet(60);
      set(8'h30, 8'h01);
      set(8'hf6, 8'h03);
      pulse(4, 10);
      rd_chk(8'hf7, 8'h10, "status");
      set(8'hf7, 8'h10);
      rd_chk(8'hf7, 8'h00, "status clear");
      set(8'hf5, 8'h18);
      set(8'hf6, 8'h02);
      pulse(120, 244);
      set(8'hf5, 8'h00);
      set(8'hf6, 8'h02);
      pulse(TS, 2 * TS + 4);
      set(8'hf5, 8'h10);
      set(8'hf6, 8'hff);
      pulse(508, 514);
      set(8'hf6, 8'h05);
      repeat (4) @(posedge clk);
      wr(1'b1, 8'h05);
      pulse(8, 14);
      set(8'hf6, 8'h05);
      repeat (3) @(posedge clk);
      wr(1'b1, 8'h00);
      quiet(40);
      for (int k = 0; k < 2; k++) begin
         set(8'hf7, (k == 1) ? 8'h80 : 8'h40);
         set(8'hf6, 8'h04);
         p0 = pulses;
         repeat (6) begin
            @(posedge clk) {mouse, kbd} <= (k == 1) ? 2'b10 : 2'b01;
            repeat (3) @(posedge clk);
            {mouse, kbd} <= 2'b00;
         end
         check("kept alive", 8'(pulses - p0), 8'h00);
         pulse(1, 16);
      end
      set(8'hf7, 8'h20);
      pulse(0, 3);
      rd_chk(8'hf7, 8'h10, "force self clear");
      wr(1'b0, 8'haa);
      set(8'hf6, 8'h01);
      rd_chk(8'hf7, 8'h00, "relocked read");
      quiet(20);
      summarize();
   end
endmodule // wdt_top_tb
